// ==== src/srmfp_regmap.sv ====
// apb register map of the serial port with its transmit and receive queues
`timescale 1ns/1ns
`default_nettype none
`include "srmfp_params.svh"

// Notes on behaviour
// R1: every instance keeps its own register set and queues, nothing shared.
// R2: all fields clear on the async reset and on the synchronous soft reset.
// R3: word, halfword and byte data views share offset zero, told apart by width.
// R4: signal control, packet size and static config sit at 0x4, 0x8, 0xc.
// R5: select timing, clock control, dma at 0x10, 0x14, 0x1c; 0x18 unassigned.
// R6: interrupt flags, interrupt enables, wakeup flags at 0x20, 0x24, 0x28.
// R7: wakeup enables at 0x2c and status at 0x30 end the map.
// R8: data port reads pop the receive queue, writes push the transmit queue.
// R9: word view is used with 4 byte transfers; resets to zero.
// R10: halfword view uses 2 byte transfers, data in bits 15:0; the code uses bits 31:16 when paddr[1] is set.
// R11: byte view uses 1 byte transfers, data in bits 7:0; the code uses the byte lane picked by paddr[1:0].
// R12: software must not read an empty queue or write a full one.
// R13: word write pushes two halfwords low first; bytes pair even and odd.
// R14: reads pop one, two or four bytes, least significant byte first.
// R15: the unassigned offset reads zero, ignores writes, touches no queue.
module srmfp_regmap (
	// clock and resets
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        soft_reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic [1:0]  psize,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// transmit halfwords toward the shifter
	output logic             txl_valid,
	output logic      [15:0] txl_data,
	input  wire logic        txl_ready,
	// receive bytes from the shifter
	input  wire logic        rxl_valid,
	input  wire logic [7:0]  rxl_data,
	output logic             rxl_ready,
	// events
	output logic             irq,
	output logic             wakeup
);
	// apb answer and stored registers
	srmfp_pkg::srmfp_word_t prdata_reg, sigctl_reg, pktsz_reg, static_reg;
	srmfp_pkg::srmfp_word_t sstime_reg, clkctl_reg, dma_reg, inten_reg, wken_reg;
	logic                   pready_reg, pslverr_reg, irq_reg, wake_reg;
	logic [`SRMFP_EV_W-1:0] intfl_reg, intfl_next;
	logic [`SRMFP_WK_W-1:0] wkfl_reg, wkfl_next;
	logic                   txe_prev_reg, rxf_prev_reg;
	// transmit queue of halfwords and its output stage
	logic [15:0]            tx_mem [0:`SRMFP_TXQ_DEPTH-5'h01];
	logic [3:0]             tx_wr_reg, tx_rd_reg;
	logic [4:0]             tx_cnt_reg;
	logic                   txl_valid_reg;
	logic [15:0]            txl_data_reg;
	// byte pairing holds
	logic [7:0]             even_reg, odd_reg;
	logic                   even_vld_reg, odd_vld_reg;
	// receive queue of bytes
	logic [7:0]             rx_mem [0:`SRMFP_RXQ_DEPTH-6'h01];
	logic [4:0]             rx_wr_reg, rx_rd_reg;
	logic [5:0]             rx_cnt_reg;
	logic                   rxl_ready_reg;

	// byte lanes kept from old where the strobe is low
	function automatic srmfp_pkg::srmfp_word_t merge(input srmfp_pkg::srmfp_word_t old_v,
		input srmfp_pkg::srmfp_word_t new_v, input logic [3:0] strb);
		srmfp_pkg::srmfp_word_t r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// byte k places ahead of the receive read pointer
	function automatic logic [7:0] rx_peek(input logic [4:0] k);
		return rx_mem[5'(rx_rd_reg + k)];
	endfunction

	// apb phase decode
	wire        setup   = psel & ~penable;
	wire        done    = psel & penable & pready_reg;
	wire [11:0] waddr   = {paddr[11:2], 2'b00};
	wire        is_data = waddr == `SRMFP_OFS_DATA; // see R3
	wire        reg_wr  = done & pwrite;
	wire        data_wr = reg_wr & is_data;
	wire        data_rd = setup & ~pwrite & is_data;
	// width of the access picks the view, all three at one offset
	wire        sz_w    = psize == srmfp_pkg::sz_word; // see R3
	wire        sz_h    = psize == srmfp_pkg::sz_half;
	wire        sz_b    = psize == srmfp_pkg::sz_byte;

	// register selects
	wire wr_sigctl = reg_wr & (waddr == `SRMFP_OFS_SIGCTL); // see R4
	wire wr_pktsz  = reg_wr & (waddr == `SRMFP_OFS_PKTSZ);
	wire wr_static = reg_wr & (waddr == `SRMFP_OFS_STATIC);
	wire wr_sstime = reg_wr & (waddr == `SRMFP_OFS_SSTIME); // see R5
	wire wr_clkctl = reg_wr & (waddr == `SRMFP_OFS_CLKCTL);
	wire wr_dma    = reg_wr & (waddr == `SRMFP_OFS_DMA);
	wire wr_intfl  = reg_wr & (waddr == `SRMFP_OFS_INTFL); // see R6
	wire wr_inten  = reg_wr & (waddr == `SRMFP_OFS_INTEN);
	wire wr_wkfl   = reg_wr & (waddr == `SRMFP_OFS_WKFL);
	wire wr_wken   = reg_wr & (waddr == `SRMFP_OFS_WKEN); // see R7
	// next enables also feed irq and wakeup, so a mask write moves the outputs at the same edge
	wire [31:0] inten_next = wr_inten ? merge(inten_reg, pwdata, pstrb) : inten_reg;
	wire [31:0] wken_next  = wr_wken ? merge(wken_reg, pwdata, pstrb) : wken_reg;
	// anything past status is an error; the hole at 0x18 is not
	wire unmapped  = waddr > `SRMFP_OFS_STAT;

	// write lanes of the data port
	wire [7:0]  wr_byte  = pwdata[8*paddr[1:0] +: 8];
	wire [15:0] wr_half  = paddr[1] ? pwdata[31:16] : pwdata[15:0];
	wire        even_in  = data_wr & sz_b & ~paddr[0];
	wire        odd_in   = data_wr & sz_b & paddr[0];
	wire        pair_go  = (even_in & odd_vld_reg) | (odd_in & even_vld_reg); // see R13
	wire [15:0] pair_w   = even_in ? {odd_reg, wr_byte} : {wr_byte, even_reg};

	// transmit push: a word is two halfwords, low one first
	wire [1:0]  tx_want  = (data_wr & sz_w) ? 2'h2 : ((data_wr & sz_h) | pair_go) ? 2'h1 : 2'h0; // see R13
	wire [15:0] tx_w0    = sz_w ? pwdata[15:0] : (sz_h ? wr_half : pair_w);
	wire [15:0] tx_w1    = pwdata[31:16];
	wire        tx_room  = (tx_cnt_reg + {3'h0, tx_want}) <= `SRMFP_TXQ_DEPTH;
	// a push that does not fit is dropped and flagged rather than corrupting the queue
	wire        tx_ovr   = (tx_want != 2'h0) & ~tx_room; // see R12
	wire [1:0]  tx_push  = tx_room ? tx_want : 2'h0;
	wire        tx_pop   = (tx_cnt_reg != 5'h00) & (~txl_valid_reg | txl_ready);
	wire [4:0]  tx_cnt_n = 5'(tx_cnt_reg + {3'h0, tx_push} - {4'h0, tx_pop});

	// receive pop: one, two or four bytes by access width
	wire [2:0]  rx_want  = data_rd ? (sz_w ? 3'h4 : (sz_h ? 3'h2 : 3'h1)) : 3'h0; // see R14
	wire        rx_ok    = {3'h0, rx_want} <= rx_cnt_reg;
	// a short read pops nothing so the queue stays consistent
	wire        rx_und   = (rx_want != 3'h0) & ~rx_ok; // see R12
	wire [2:0]  rx_pop   = rx_ok ? rx_want : 3'h0;
	wire        rx_push  = rxl_valid & rxl_ready_reg;
	wire [5:0]  rx_cnt_n = 6'(rx_cnt_reg + {5'h0, rx_push} - {3'h0, rx_pop});

	// read data of the port: oldest byte in the least significant lane
	wire [31:0] rx_word  = {rx_peek(5'h03), rx_peek(5'h02), rx_peek(5'h01), rx_peek(5'h00)}; // see R14
	wire [31:0] rd_half  = {16'h0000, rx_word[15:0]} << (16 * paddr[1]); // see R10
	wire [31:0] rd_byte  = {24'h00_0000, rx_word[7:0]} << (8 * paddr[1:0]); // see R11
	wire [31:0] rd_port  = sz_w ? rx_word : (sz_h ? rd_half : rd_byte); // see R9

	// status: tx count 4:0, rx count 13:8, held even 16, held odd 17
	wire [31:0] stat_w   = {14'h0000, odd_vld_reg, even_vld_reg, 2'h0, rx_cnt_reg, 3'h0, tx_cnt_reg};

	// read selection; the hole and unmapped offsets read zero
	wire [31:0] rd_value =
		is_data                         ? rd_port                    :
		waddr == `SRMFP_OFS_SIGCTL      ? sigctl_reg                 :
		waddr == `SRMFP_OFS_PKTSZ       ? pktsz_reg                  :
		waddr == `SRMFP_OFS_STATIC      ? static_reg                 :
		waddr == `SRMFP_OFS_SSTIME      ? sstime_reg                 :
		waddr == `SRMFP_OFS_CLKCTL      ? clkctl_reg                 :
		waddr == `SRMFP_OFS_DMA         ? dma_reg                    :
		waddr == `SRMFP_OFS_INTFL       ? {28'h0, intfl_reg}         :
		waddr == `SRMFP_OFS_INTEN       ? inten_reg                  :
		waddr == `SRMFP_OFS_WKFL        ? {30'h0, wkfl_reg}          :
		waddr == `SRMFP_OFS_WKEN        ? wken_reg                   :
		waddr == `SRMFP_OFS_STAT        ? stat_w                     :
		`SRMFP_RST_WORD; // see R15

	// event sources: empty and full fire once on entry, errors fire per access
	wire txe_now = (tx_cnt_reg == 5'h00) & ~txl_valid_reg;
	wire rxf_now = rx_cnt_reg == `SRMFP_RXQ_DEPTH;
	wire [`SRMFP_EV_W-1:0] ev_set = {rx_und, tx_ovr, rxf_now & ~rxf_prev_reg, txe_now & ~txe_prev_reg};

	// write one to clear; a set in the same cycle wins over the clear
	always_comb begin
		intfl_next = intfl_reg;
		if (wr_intfl & pstrb[0]) begin
			intfl_next = intfl_reg & ~pwdata[`SRMFP_EV_W-1:0];
		end
		intfl_next = intfl_next | ev_set;
		wkfl_next = wkfl_reg;
		if (wr_wkfl & pstrb[0]) begin
			wkfl_next = wkfl_reg & ~pwdata[`SRMFP_WK_W-1:0];
		end
		wkfl_next = wkfl_next | ev_set[`SRMFP_WK_W-1:0];
	end

	// apb answer: data is taken at setup so pready comes in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= `SRMFP_RST_WORD;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & unmapped;
			prdata_reg  <= (setup & ~pwrite) ? rd_value : `SRMFP_RST_WORD;
		end
	end

	// stored registers; each instance has its own copy
	always_ff @(posedge pclk or negedge presetn) begin // see R1
		if (!presetn) begin // see R2
			sigctl_reg <= `SRMFP_RST_WORD;
			pktsz_reg  <= `SRMFP_RST_WORD;
			static_reg <= `SRMFP_RST_WORD;
			sstime_reg <= `SRMFP_RST_WORD;
			clkctl_reg <= `SRMFP_RST_WORD;
			dma_reg    <= `SRMFP_RST_WORD;
			inten_reg  <= `SRMFP_RST_WORD;
			wken_reg   <= `SRMFP_RST_WORD;
		end else if (soft_reset) begin // see R2
			sigctl_reg <= `SRMFP_RST_WORD;
			pktsz_reg  <= `SRMFP_RST_WORD;
			static_reg <= `SRMFP_RST_WORD;
			sstime_reg <= `SRMFP_RST_WORD;
			clkctl_reg <= `SRMFP_RST_WORD;
			dma_reg    <= `SRMFP_RST_WORD;
			inten_reg  <= `SRMFP_RST_WORD;
			wken_reg   <= `SRMFP_RST_WORD;
		end else begin
			sigctl_reg <= wr_sigctl ? merge(sigctl_reg, pwdata, pstrb) : sigctl_reg; // see R4
			pktsz_reg  <= wr_pktsz  ? merge(pktsz_reg, pwdata, pstrb)  : pktsz_reg;
			static_reg <= wr_static ? merge(static_reg, pwdata, pstrb) : static_reg;
			sstime_reg <= wr_sstime ? merge(sstime_reg, pwdata, pstrb) : sstime_reg; // see R5
			clkctl_reg <= wr_clkctl ? merge(clkctl_reg, pwdata, pstrb) : clkctl_reg;
			dma_reg    <= wr_dma    ? merge(dma_reg, pwdata, pstrb)    : dma_reg;
			inten_reg  <= inten_next; // see R6
			wken_reg   <= wken_next; // see R7
		end
	end

	// flags and the two level outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin // see R2
			intfl_reg    <= '0;
			wkfl_reg     <= '0;
			txe_prev_reg <= 1'b0;
			rxf_prev_reg <= 1'b0;
			irq_reg      <= 1'b0;
			wake_reg     <= 1'b0;
		end else if (soft_reset) begin
			intfl_reg    <= '0;
			wkfl_reg     <= '0;
			txe_prev_reg <= 1'b0;
			rxf_prev_reg <= 1'b0;
			irq_reg      <= 1'b0;
			wake_reg     <= 1'b0;
		end else begin
			intfl_reg    <= intfl_next;
			wkfl_reg     <= wkfl_next;
			txe_prev_reg <= txe_now;
			rxf_prev_reg <= rxf_now;
			irq_reg      <= |(intfl_next & inten_next[`SRMFP_EV_W-1:0]); // see R6
			wake_reg     <= |(wkfl_next & wken_next[`SRMFP_WK_W-1:0]); // see R7
		end
	end

	// even and odd byte holds; a lone byte waits for its partner
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			even_vld_reg <= 1'b0;
			odd_vld_reg  <= 1'b0;
			even_reg     <= 8'h00;
			odd_reg      <= 8'h00;
		end else if (soft_reset) begin
			even_vld_reg <= 1'b0;
			odd_vld_reg  <= 1'b0;
			even_reg     <= 8'h00;
			odd_reg      <= 8'h00;
		end else begin
			even_vld_reg <= pair_go ? 1'b0 : (even_in | even_vld_reg); // see R13
			odd_vld_reg  <= pair_go ? 1'b0 : (odd_in | odd_vld_reg);
			even_reg     <= even_in ? wr_byte : even_reg;
			odd_reg      <= odd_in ? wr_byte : odd_reg;
		end
	end

	// transmit queue pointers; queue contents need no reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wr_reg  <= 4'h0;
			tx_rd_reg  <= 4'h0;
			tx_cnt_reg <= 5'h00;
		end else if (soft_reset) begin
			tx_wr_reg  <= 4'h0;
			tx_rd_reg  <= 4'h0;
			tx_cnt_reg <= 5'h00;
		end else begin
			tx_wr_reg  <= 4'(tx_wr_reg + {2'h0, tx_push}); // see R8
			tx_rd_reg  <= 4'(tx_rd_reg + {3'h0, tx_pop});
			tx_cnt_reg <= tx_cnt_n;
		end
	end

	// transmit storage, lower halfword in the older slot
	always_ff @(posedge pclk) begin
		if (tx_push != 2'h0) begin
			tx_mem[tx_wr_reg] <= tx_w0; // see R13
		end
		if (tx_push == 2'h2) begin
			tx_mem[4'(tx_wr_reg + 4'h1)] <= tx_w1;
		end
	end

	// output stage keeps the link data straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txl_valid_reg <= 1'b0;
			txl_data_reg  <= 16'h0000;
		end else if (soft_reset) begin
			txl_valid_reg <= 1'b0;
			txl_data_reg  <= 16'h0000;
		end else if (tx_pop) begin
			txl_valid_reg <= 1'b1;
			txl_data_reg  <= tx_mem[tx_rd_reg];
		end else if (txl_ready) begin
			txl_valid_reg <= 1'b0;
		end
	end

	// receive queue pointers and the registered ready toward the shifter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wr_reg     <= 5'h00;
			rx_rd_reg     <= 5'h00;
			rx_cnt_reg    <= 6'h00;
			rxl_ready_reg <= 1'b0;
		end else if (soft_reset) begin
			rx_wr_reg     <= 5'h00;
			rx_rd_reg     <= 5'h00;
			rx_cnt_reg    <= 6'h00;
			rxl_ready_reg <= 1'b0;
		end else begin
			rx_wr_reg     <= 5'(rx_wr_reg + {4'h0, rx_push});
			rx_rd_reg     <= 5'(rx_rd_reg + {2'h0, rx_pop}); // see R8
			rx_cnt_reg    <= rx_cnt_n;
			rxl_ready_reg <= rx_cnt_n < `SRMFP_RXQ_DEPTH;
		end
	end

	// receive storage
	always_ff @(posedge pclk) begin
		if (rx_push) begin
			rx_mem[rx_wr_reg] <= rxl_data;
		end
	end

	// outputs
	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign txl_valid = txl_valid_reg;
	assign txl_data  = txl_data_reg;
	assign rxl_ready = rxl_ready_reg;
	assign irq       = irq_reg;
	assign wakeup    = wake_reg;

	// checks
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		setup |=> pready_reg ##1 !pready_reg)
		else $error("apb answer not exactly one access cycle");
	word_push_a: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		(data_wr & sz_w & tx_room & !soft_reset) |=>
		tx_cnt_reg == 5'($past(tx_cnt_reg) + 5'h02 - {4'h0, $past(tx_pop)}))
		else $error("word write did not queue two halfwords");
	byte_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		(even_in & !odd_vld_reg & !soft_reset) |=>
		even_vld_reg && tx_cnt_reg == 5'($past(tx_cnt_reg) - {4'h0, $past(tx_pop)}))
		else $error("lone byte was queued");
	rx_pop_a: assert property (@(posedge pclk) disable iff (!presetn) // see R14
		(data_rd & sz_w & rx_ok & !soft_reset) |=>
		rx_cnt_reg == 6'($past(rx_cnt_reg) - 6'h04 + {5'h0, $past(rx_push)}))
		else $error("word read did not pop four bytes");
	read_order_a: assert property (@(posedge pclk) disable iff (!presetn) // see R14
		(data_rd & sz_b & paddr[1:0] == 2'h0) |=> prdata_reg[7:0] == $past(rx_mem[rx_rd_reg]))
		else $error("byte read not taken from queue head");
	hole_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // see R15
		(setup & waddr == `SRMFP_OFS_HOLE) |=> prdata_reg == `SRMFP_RST_WORD && !pslverr_reg)
		else $error("unassigned offset answered");
	soft_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
		soft_reset |=> tx_cnt_reg == 5'h00 && rx_cnt_reg == 6'h00 && intfl_reg == '0 && inten_reg == '0)
		else $error("soft reset left state behind");
	flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
		(!wr_intfl & !soft_reset) |=> (($past(intfl_reg) & ~intfl_reg) == '0))
		else $error("interrupt flag dropped without a clear");
	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
		irq_reg == |(intfl_reg & inten_reg[`SRMFP_EV_W-1:0]))
		else $error("interrupt output disagrees with flags");
	cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(wr_static & pstrb == 4'hf & !soft_reset) |=> static_reg == $past(pwdata))
		else $error("static config write lost");
endmodule
`default_nettype wire

// ==== src/srmfp_params.svh ====
// offsets, field positions, reset values and queue sizes of the serial port register map
`ifndef SRMFP_PARAMS_SVH
`define SRMFP_PARAMS_SVH
`define SRMFP_OFS_DATA     12'h000
`define SRMFP_OFS_SIGCTL   12'h004
`define SRMFP_OFS_PKTSZ    12'h008
`define SRMFP_OFS_STATIC   12'h00c
`define SRMFP_OFS_SSTIME   12'h010
`define SRMFP_OFS_CLKCTL   12'h014
`define SRMFP_OFS_HOLE     12'h018
`define SRMFP_OFS_DMA      12'h01c
`define SRMFP_OFS_INTFL    12'h020
`define SRMFP_OFS_INTEN    12'h024
`define SRMFP_OFS_WKFL     12'h028
`define SRMFP_OFS_WKEN     12'h02c
`define SRMFP_OFS_STAT     12'h030
`define SRMFP_RST_WORD     32'h0000_0000
`define SRMFP_TXQ_DEPTH    5'h10
`define SRMFP_RXQ_DEPTH    6'h20
`define SRMFP_EV_TXEMPTY   0
`define SRMFP_EV_RXFULL    1
`define SRMFP_EV_TXOVR     2
`define SRMFP_EV_RXUND     3
`define SRMFP_EV_W         4
`define SRMFP_WK_W         2
`endif

// ==== src/srmfp_pkg.sv ====
// types shared by the serial port register map
package srmfp_pkg;
	typedef enum logic [1:0] {
		sz_byte = 2'b00,
		sz_half = 2'b01,
		sz_word = 2'b10
	} srmfp_size_e;
	typedef logic [31:0] srmfp_word_t;
endpackage

// ==== test/srmfp_link_model.sv ====
// behavioural shifter side: drains transmit halfwords and feeds receive bytes
`timescale 1ns/1ns
`default_nettype none
module srmfp_link_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// pacing: 0 always ready, 1 random stalls, 2 blocked
	input  wire logic [1:0]  tx_mode,
	// transmit halfwords from the register map
	input  wire logic        txl_valid,
	input  wire logic [15:0] txl_data,
	output logic             txl_ready,
	// receive bytes toward the register map
	output logic             rxl_valid,
	output logic      [7:0]  rxl_data,
	input  wire logic        rxl_ready
);
	// halfwords taken and bytes still to send, reached by the bench
	logic [15:0] tx_seen[$];
	logic [7:0]  rx_q[$];

	// one byte stands until taken; an idle data line shows the inverse of the last value,
	// so a design that samples it outside a handshake picks up garbage, not a lucky copy
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txl_ready <= 1'b0;
			rxl_valid <= 1'b0;
			rxl_data  <= 8'h00;
		end else begin
			if (txl_valid && txl_ready)
				tx_seen.push_back(txl_data);
			txl_ready <= (tx_mode == 2'd0) || (tx_mode == 2'd1 && 1'($urandom_range(0, 1)));
			if (rxl_valid && rxl_ready)
				void'(rx_q.pop_front());
			if (rx_q.size() > 0) begin
				rxl_valid <= 1'b1;
				rxl_data  <= rx_q[0];
			end else begin
				rxl_valid <= 1'b0;
				rxl_data  <= ~rxl_data;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the serial port register map
`timescale 1ns/1ns
`default_nettype none
`include "srmfp_params.svh"
module tb;
	// apb side
	logic        pclk;
	logic        presetn;
	logic        soft_reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [1:0]  psize;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// link side and events
	logic        txl_valid;
	logic [15:0] txl_data;
	logic        txl_ready;
	logic        rxl_valid;
	logic [7:0]  rxl_data;
	logic        rxl_ready;
	logic        irq;
	logic        wakeup;
	logic [1:0]  tx_mode;
	// bench state and reference queues
	int          errors;
	int          check_count;
	logic [15:0] tx_exp[$];
	logic [7:0]  rx_exp[$];
	logic [31:0] rd;
	logic        err;
	logic [31:0] d;
	logic [31:0] rw_val[8];
	logic [11:0] rw_ofs[8] = '{`SRMFP_OFS_SIGCTL, `SRMFP_OFS_PKTSZ, `SRMFP_OFS_STATIC, `SRMFP_OFS_SSTIME,
		`SRMFP_OFS_CLKCTL, `SRMFP_OFS_DMA, `SRMFP_OFS_INTEN, `SRMFP_OFS_WKEN};
	localparam logic [1:0] W = srmfp_pkg::sz_word;
	localparam logic [1:0] H = srmfp_pkg::sz_half;
	localparam logic [1:0] B = srmfp_pkg::sz_byte;

	srmfp_regmap i_dut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .psize(psize),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txl_valid(txl_valid), .txl_data(txl_data),
		.txl_ready(txl_ready), .rxl_valid(rxl_valid), .rxl_data(rxl_data), .rxl_ready(rxl_ready),
		.irq(irq), .wakeup(wakeup));
	srmfp_link_model i_link (.pclk(pclk), .presetn(presetn), .tx_mode(tx_mode), .txl_valid(txl_valid),
		.txl_data(txl_data), .txl_ready(txl_ready), .rxl_valid(rxl_valid), .rxl_data(rxl_data),
		.rxl_ready(rxl_ready));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d, checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] wd, input logic [1:0] sz);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= we;
		paddr   <= a;
		pwdata  <= wd;
		psize   <= sz;
		pstrb   <= (sz == W) ? 4'hf : (sz == H) ? (a[1] ? 4'hc : 4'h3) : 4'(4'h1 << a[1:0]);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			complete_run();
		end
	endtask

	// bounded wait for the receive count in status
	task automatic wait_rx(input logic [5:0] cnt);
		int n;
		n = 0;
		do begin
			apb(1'b0, `SRMFP_OFS_STAT, 32'h0, W);
			n++;
		end while (rd[13:8] !== cnt && n < 100);
		if (rd[13:8] !== cnt) begin
			check(32'(rd[13:8]), 32'(cnt));
			complete_run();
		end
	endtask

	// bounded wait for the link to take every expected halfword, then compare in order
	task automatic drain_tx();
		int n;
		n = 0;
		while (i_link.tx_seen.size() < tx_exp.size() && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		if (i_link.tx_seen.size() < tx_exp.size()) begin
			errors++;
			complete_run();
		end
		while (tx_exp.size() > 0)
			check(32'(i_link.tx_seen.pop_front()), 32'(tx_exp.pop_front()));
	endtask

	initial begin
		presetn = 1'b0;
		soft_reset = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		psize = 2'h0;
		tx_mode = 2'd1;
		errors = 0;
		check_count = 0;
		d = $urandom(32'h2708cc9a);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		// reset values, then random write and read back of every storage register
		foreach (rw_ofs[i]) begin
			apb(1'b0, rw_ofs[i], 32'h0, W);
			check(rd, `SRMFP_RST_WORD);
			rw_val[i] = $urandom;
			apb(1'b1, rw_ofs[i], rw_val[i], W);
		end
		apb(1'b0, `SRMFP_OFS_INTFL, 32'h0, W);
		check(rd, 32'h0000_0001);
		foreach (rw_ofs[i]) begin
			apb(1'b0, rw_ofs[i], 32'h0, W);
			check(rd, rw_val[i]);
		end
		// soft reset clears every storage register
		@(posedge pclk);
		soft_reset <= 1'b1;
		@(posedge pclk);
		soft_reset <= 1'b0;
		foreach (rw_ofs[i]) begin
			apb(1'b0, rw_ofs[i], 32'h0, W);
			check(rd, `SRMFP_RST_WORD);
		end
		// unassigned offset and beyond the map
		apb(1'b1, `SRMFP_OFS_HOLE, $urandom, W);
		apb(1'b0, `SRMFP_OFS_HOLE, 32'h0, W);
		check({rd[31:1], err}, 32'h0);
		apb(1'b0, 12'h034, 32'h0, W);
		check({rd[31:1], err}, 32'h1);
		apb(1'b0, `SRMFP_OFS_STAT, 32'h0, W);
		check(rd, 32'h0);
		// transmit through all three widths with a stalling link
		d = $urandom;
		apb(1'b1, `SRMFP_OFS_DATA, d, W);
		tx_exp.push_back(d[15:0]);
		tx_exp.push_back(d[31:16]);
		apb(1'b1, 12'h002, d, H);
		tx_exp.push_back(d[31:16]);
		apb(1'b1, 12'h001, d, B);
		apb(1'b1, 12'h000, d, B);
		tx_exp.push_back(d[15:0]);
		drain_tx();
		// block the link, overfill: eight words leave one slot of queue and stage free, the ninth does not fit and is dropped whole
		tx_mode <= 2'd2;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			d = $urandom;
			apb(1'b1, `SRMFP_OFS_DATA, d, W);
			if (i < 8) begin
				tx_exp.push_back(d[15:0]);
				tx_exp.push_back(d[31:16]);
			end
		end
		apb(1'b0, `SRMFP_OFS_INTFL, 32'h0, W);
		check(rd & 32'h4, 32'h4);
		apb(1'b1, `SRMFP_OFS_INTEN, 32'h4, W);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h1);
		apb(1'b1, `SRMFP_OFS_INTEN, 32'h0, W);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h0);
		apb(1'b1, `SRMFP_OFS_INTFL, 32'h4, W);
		apb(1'b0, `SRMFP_OFS_INTFL, 32'h0, W);
		check(rd & 32'h4, 32'h0);
		tx_mode <= 2'd0;
		drain_tx();
		// receive: fill to full, then drain with every width
		for (int i = 0; i < 36; i++) begin
			d[7:0] = 8'($urandom);
			rx_exp.push_back(d[7:0]);
			if (i < 34)
				i_link.rx_q.push_back(d[7:0]);
		end
		wait_rx(6'h20);
		apb(1'b0, `SRMFP_OFS_INTFL, 32'h0, W);
		check(rd & 32'h2, 32'h2);
		apb(1'b1, `SRMFP_OFS_WKEN, 32'h2, W);
		repeat (3) @(posedge pclk);
		check(32'(wakeup), 32'h1);
		apb(1'b1, `SRMFP_OFS_WKFL, 32'h2, W);
		repeat (3) @(posedge pclk);
		check(32'(wakeup), 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, `SRMFP_OFS_DATA, 32'h0, W);
			check(rd, {rx_exp[3], rx_exp[2], rx_exp[1], rx_exp[0]});
			repeat (4) void'(rx_exp.pop_front());
		end
		wait_rx(6'h02);
		apb(1'b0, 12'h002, 32'h0, H);
		check({16'h0, rd[31:16]}, {16'h0, rx_exp[1], rx_exp[0]});
		repeat (2) void'(rx_exp.pop_front());
		i_link.rx_q.push_back(rx_exp[0]);
		i_link.rx_q.push_back(rx_exp[1]);
		wait_rx(6'h02);
		apb(1'b0, 12'h003, 32'h0, B);
		check({24'h0, rd[31:24]}, {24'h0, rx_exp.pop_front()});
		apb(1'b0, 12'h000, 32'h0, B);
		check({24'h0, rd[7:0]}, {24'h0, rx_exp.pop_front()});
		// reading an empty queue raises the short-read flag
		apb(1'b0, `SRMFP_OFS_DATA, 32'h0, B);
		apb(1'b0, `SRMFP_OFS_INTFL, 32'h0, W);
		check(rd & 32'h8, 32'h8);
		complete_run();
	end
endmodule
`default_nettype wire
